//--- core/tcsc_consts.svh
`ifndef TCSC_CONSTS_SVH
`define TCSC_CONSTS_SVH
// register byte addresses
`define TCSC_ADDR_CONTROL   12'h000
`define TCSC_ADDR_COUNT     12'h004
`define TCSC_ADDR_STATUS    12'h008
// only whole-word bus transfers are taken
`define TCSC_SIZE_WORD      3'h2
// control register fields
`define TCSC_CS_HI          7
`define TCSC_CS_LO          6
`define TCSC_PS_HI          5
`define TCSC_PS_LO          4
`define TCSC_OSCEN_BIT      3
`define TCSC_SYNC_BIT       2
`define TCSC_RUN_BIT        0
`define TCSC_CTRL_WMASK     8'hfd
`define TCSC_CTRL_RESET     8'h00
// instruction clock is the system clock divided by this
`define TCSC_INSTR_DIV      4
`define TCSC_COUNT_RESET    16'h0000
`endif

//--- core/tcsc_pkg.sv
`default_nettype none
package tcsc_pkg;
    // clock source choices
    typedef enum logic [1:0] {
        TCSC_SRC_INSTR = 2'h0,
        TCSC_SRC_SYS   = 2'h1,
        TCSC_SRC_EXT   = 2'h2,
        TCSC_SRC_CAP   = 2'h3
    } tcsc_src_t;
    // bus slave phase
    typedef enum logic [0:0] {
        TCSC_BUS_IDLE,
        TCSC_BUS_DATA
    } tcsc_bus_t;
endpackage
`default_nettype wire

//--- core/tcsc_sync2.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for one asynchronous level
module tcsc_sync2
(
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_r; // first stage, read only by second stage

    // two flops in series
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_r   <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // tcsc_sync2
`default_nettype wire

//--- core/tcsc_edge.sv
`timescale 1ns/1ps
`default_nettype none
// rising edge detector on an already synchronised level
module tcsc_edge
(
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic level_in,
    output logic      rise
);
    logic last_r; // previous sample

    // remember last level
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            last_r <= 1'b0;
        else
            last_r <= level_in;
    end

    // one pulse on each low to high step
    assign rise = level_in & ~last_r;
endmodule // tcsc_edge
`default_nettype wire

//--- core/tcsc_top.sv
// Function
// - source 11 selects capacitive sensing oscillator
// - source 10, oscillator off: count pin rises
// - source 10, oscillator on: crystal clocks timer
// - source 01 clocks timer from system clock
// - source 00 uses system clock over four
// - prescale field divides by 1,2,4,8
// - bit 3 enables dedicated low-power oscillator
// - external source, oscillator off: bit 2 bypasses synchroniser
// - internal source ignores synchroniser bit
// - bit 0 runs timer; clear stops, clears gate
// - bit 1 reads zero, writes ignored
// - control bits reset to zero on power reset
`timescale 1ns/1ps
`default_nettype none
`include "tcsc_consts.svh"
module tcsc_top
(
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // clock source pins
    input  wire logic        ext_clock_pin,
    input  wire logic        crystal_in_pin,
    output logic             crystal_out_pin,
    input  wire logic        cap_sense_oscillator,
    // timer gate from outside, and state
    input  wire logic        gate_set,
    output logic             dedicated_osc_enable,
    output logic             gate_ff,
    output logic      [15:0] timer_count
);
    import tcsc_pkg::*;

    logic [7:0]  timer_control_r;      // control register
    logic [11:0] addr_r;               // latched address
    logic        wr_r;                 // latched write
    tcsc_bus_t   bus_r;                // data phase pending
    tcsc_src_t   clock_source_select;  // source field
    logic [1:0]  prescale_select;      // prescale field
    logic        ext_clock_sync_bypass;// bypass synchroniser
    logic        timer_run;            // timer on
    logic        ext_sync;             // synchronised pin
    logic        xtal_sync;            // synchronised crystal
    logic        cap_sync;             // synchronised cap osc
    logic        ext_raw_r;            // unsynchronised one-flop sample
    logic        ext_raw_last_r;       // second raw stage, settled
    logic        ext_raw_prev_r;       // previous settled raw level
    logic        ext_rise_s;           // synchronised pin edge
    logic        xtal_rise;            // crystal edge
    logic        cap_rise;             // cap osc edge
    logic [1:0]  instr_cnt_r;          // system clock divider
    logic        src_tick;             // selected source tick
    logic [2:0]  pre_cnt_r;            // prescaler count
    logic [2:0]  pre_top;              // prescaler last value
    logic        pre_tick;             // prescaler output
    logic        addr_ok;              // transfer request
    logic        ext_tick;             // external tick after sync choice
    logic        size_ok;              // whole-word transfer

    // fields out of the control register
    // bit 1 is never stored, so no slice can pick it up
    assign clock_source_select   = tcsc_src_t'(timer_control_r[`TCSC_CS_HI:`TCSC_CS_LO]);
    assign prescale_select       = timer_control_r[`TCSC_PS_HI:`TCSC_PS_LO];
    assign dedicated_osc_enable  = timer_control_r[`TCSC_OSCEN_BIT];
    assign ext_clock_sync_bypass = timer_control_r[`TCSC_SYNC_BIT];
    assign timer_run             = timer_control_r[`TCSC_RUN_BIT];

    // crystal driver inverts input only while oscillator enabled
    // with the enable low the output rests low, amplifier off
    // this is a pad driver path, not clocked logic
    assign crystal_out_pin = dedicated_osc_enable & ~crystal_in_pin;

    // synchronisers for the asynchronous sources
    // every source pin passes two flops before any clocked logic looks at it
    // the three sources have no phase relation to ref_clk
    tcsc_sync2 u_sync_ext
    (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .async_in (ext_clock_pin),
        .sync_out (ext_sync)
    );
    tcsc_sync2 u_sync_xtal
    (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .async_in (crystal_in_pin),
        .sync_out (xtal_sync)
    );
    tcsc_sync2 u_sync_cap
    (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .async_in (cap_sense_oscillator),
        .sync_out (cap_sync)
    );

    // edge detectors on synchronised levels
    // a pin resting high at reset release gives one early tick;
    // harmless, since the timer is stopped after reset
    tcsc_edge u_edge_ext
    (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .level_in (ext_sync),
        .rise     (ext_rise_s)
    );
    tcsc_edge u_edge_xtal
    (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .level_in (xtal_sync),
        .rise     (xtal_rise)
    );
    tcsc_edge u_edge_cap
    (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .level_in (cap_sync),
        .rise     (cap_rise)
    );

    // bypass path: a plain flop chain, no synchroniser instance;
    // the first stage is read only by the second, so a metastable
    // sample never reaches the edge logic
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ext_raw_r      <= 1'b0;
            ext_raw_last_r <= 1'b0;
            ext_raw_prev_r <= 1'b0;
        end
        else
        begin
            ext_raw_r      <= ext_clock_pin;
            ext_raw_last_r <= ext_raw_r;
            ext_raw_prev_r <= ext_raw_last_r;
        end
    end

    // external tick: pin or crystal, synchronised or not
    // the crystal wins over the pin while the dedicated oscillator runs
    always_comb
    begin
        if (dedicated_osc_enable)
            ext_tick = xtal_rise;
        else if (ext_clock_sync_bypass)
            ext_tick = ext_raw_last_r & ~ext_raw_prev_r;
        else
            ext_tick = ext_rise_s;
    end

    // instruction clock divider, free running
    // free running, so the instruction phase never depends on writes
    // two bits, wrapping at four
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            instr_cnt_r <= 2'h0;
        else
            instr_cnt_r <= instr_cnt_r + 2'h1;
    end

    // source selection; internal sources never look at sync bit
    // the system clock source steps on every edge
    // the sensing oscillator ticks on its synchronised rising edge
    always_comb
    begin
        case (clock_source_select)
            TCSC_SRC_INSTR: src_tick = (instr_cnt_r == 2'(`TCSC_INSTR_DIV - 1));
            TCSC_SRC_SYS:   src_tick = 1'b1;
            TCSC_SRC_EXT:   src_tick = ext_tick;
            default:        src_tick = cap_rise;
        endcase
    end

    // prescaler terminal count
    // top is one less than the division ratio
    // the count runs from 0 to top, then wraps on the next tick
    always_comb
    begin
        case (prescale_select)
            2'h0:    pre_top = 3'h0;
            2'h1:    pre_top = 3'h1;
            2'h2:    pre_top = 3'h3;
            default: pre_top = 3'h7;
        endcase
    end
    // tick qualified by run, so a stopped timer never steps
    assign pre_tick = timer_run & src_tick & (pre_cnt_r >= pre_top);

    // prescaler counts source ticks; cleared while stopped
    // clearing on stop makes every start begin a whole division
    // while running, only a source tick moves it
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            pre_cnt_r <= 3'h0;
        else if (!timer_run)
            pre_cnt_r <= 3'h0;
        else if (pre_tick)
            pre_cnt_r <= 3'h0;
        else if (src_tick)
            pre_cnt_r <= pre_cnt_r + 3'h1;
    end

    // timer counter advances on prescaler tick, holds when stopped
    // wraps silently at the top of its sixteen bits
    // never written by the bus, so software only reads it
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            timer_count <= `TCSC_COUNT_RESET;
        else if (pre_tick)
            timer_count <= timer_count + 16'h0001;
    end

    // gate flip-flop; set from outside, cleared while timer off
    // a stop beats a gate request in the same cycle
    // gate_set comes from logic on ref_clk, so no synchroniser
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            gate_ff <= 1'b0;
        else if (!timer_run)
            gate_ff <= 1'b0;
        else if (gate_set)
            gate_ff <= 1'b1;
    end

    // ahb address phase; only whole-word transfers are taken
    // a narrower transfer still answers okay but changes nothing
    assign size_ok = (hsize == `TCSC_SIZE_WORD);
    assign addr_ok = hsel & hready & htrans[1] & size_ok;

    // latch address phase for the data phase
    // captured only while the bus is ready
    // size is not kept: a taken transfer is always a word
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bus_r  <= TCSC_BUS_IDLE;
            addr_r <= 12'h000;
            wr_r   <= 1'b0;
        end
        else if (hready)
        begin
            bus_r  <= addr_ok ? TCSC_BUS_DATA : TCSC_BUS_IDLE;
            addr_r <= haddr;
            wr_r   <= hwrite;
        end
    end

    // control register write in data phase; bit 1 kept zero
    // the write lands on the edge that ends the data phase
    // bit 1 is masked to zero on the way in
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            timer_control_r <= `TCSC_CTRL_RESET;
        else if (bus_r == TCSC_BUS_DATA && wr_r && addr_r == `TCSC_ADDR_CONTROL)
            timer_control_r <= hwdata[7:0] & `TCSC_CTRL_WMASK;
    end

    // read data registered at the address phase, valid in data phase
    // it then stands until the next read address phase
    // unmapped offsets read zero
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            hrdata <= 32'h0000_0000;
        else if (addr_ok && !hwrite)
        begin
            if (haddr == `TCSC_ADDR_CONTROL)
                hrdata <= {24'h00_0000, timer_control_r & `TCSC_CTRL_WMASK};
            else if (haddr == `TCSC_ADDR_COUNT)
                hrdata <= {16'h0000, timer_count};
            else if (haddr == `TCSC_ADDR_STATUS)
                hrdata <= {30'h0000_0000, gate_ff, pre_tick};
            else
                hrdata <= 32'h0000_0000; // unmapped reads zero
        end
    end

    // zero wait states, always okay
    // no access needs more than one cycle, so the slave never stalls
    // errors are never signalled
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
endmodule // tcsc_top
`default_nettype wire

//--- test/tcsc_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side: free-running pin clock, crystal and sensing oscillator
// every level lasts over two ref_clk cycles, phases unrelated to ref_clk
module tcsc_src_model
(
    output logic ext_clock_pin,
    output logic crystal_in_pin,
    output logic cap_sense_oscillator
);
    // external pin clock
    initial
    begin
        ext_clock_pin = 1'b0;
        forever #11.3 ext_clock_pin = ~ext_clock_pin;
    end
    // crystal input
    initial
    begin
        crystal_in_pin = 1'b0;
        forever #13.7 crystal_in_pin = ~crystal_in_pin;
    end
    // sensing oscillator
    initial
    begin
        cap_sense_oscillator = 1'b0;
        forever #17.1 cap_sense_oscillator = ~cap_sense_oscillator;
    end
endmodule // tcsc_src_model
`default_nettype wire

//--- test/tcsc_top_props.sv
`timescale 1ns/1ps
`default_nettype none
// checker on the top ports; tracks the control value from bus writes
module tcsc_top_props
(
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        crystal_in_pin,
    input wire logic        crystal_out_pin,
    input wire logic        dedicated_osc_enable,
    input wire logic        gate_ff,
    input wire logic [15:0] timer_count
);
    logic        wr_r;   // write data phase pending
    logic        rd_r;   // read data phase pending
    logic [11:0] a_r;    // captured address
    logic [7:0]  ctl_r;  // shadow of the control value
    logic [3:0]  age_r;  // cycles since last control write, saturating
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // address capture and shadow control update at the data phase
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_r  <= 1'b0;
            rd_r  <= 1'b0;
            a_r   <= 12'h000;
            ctl_r <= 8'h00;
        end
        else
        begin
            wr_r <= hsel && hready && htrans[1] && hwrite;
            rd_r <= hsel && hready && htrans[1] && !hwrite;
            a_r  <= haddr;
            if (wr_r && a_r == 12'h000)
                ctl_r <= hwdata[7:0] & 8'hfd;
        end
    end
    // settle counter after each control write
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            age_r <= 4'h0;
        else if (wr_r && a_r == 12'h000)
            age_r <= 4'h0;
        else if (age_r != 4'hf)
            age_r <= age_r + 4'h1;
    end
    a_ready_high: assert property (hreadyout) else $error("slave stalled");
    a_resp_okay: assert property (!hresp) else $error("error response");
    a_ctrl_read: assert property (rd_r && a_r == 12'h000 |->
        hrdata == {24'h00_0000, ctl_r}) else $error("control read mismatch");
    a_osc_enable: assert property (dedicated_osc_enable == ctl_r[3])
        else $error("oscillator enable wrong");
    a_crystal_drive: assert property (
        crystal_out_pin == (dedicated_osc_enable & ~crystal_in_pin))
        else $error("crystal drive wrong");
    a_count_hold: assert property (!ctl_r[0] && age_r > 4 |=> $stable(timer_count))
        else $error("count moved while stopped");
    a_sys_rate: assert property (ctl_r[7:4] == 4'h4 && ctl_r[0] && age_r > 4 |=>
        timer_count == $past(timer_count) + 16'h0001) else $error("system rate wrong");
    a_instr_rate: assert property (ctl_r[7:4] == 4'h0 && ctl_r[0] && age_r > 8 &&
        $changed(timer_count) |=> $stable(timer_count) [*3]) else $error("instruction rate wrong");
    a_step_one: assert property ($changed(timer_count) |->
        timer_count == $past(timer_count) + 16'h0001) else $error("count jumped");
    a_gate_stop: assert property (!ctl_r[0] |-> ##1 !gate_ff)
        else $error("gate set while stopped");
endmodule // tcsc_top_props
bind tcsc_top tcsc_top_props u_props (.ref_clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hwdata, .hrdata, .hreadyout, .hresp, .crystal_in_pin, .crystal_out_pin,
    .dedicated_osc_enable, .gate_ff, .timer_count);
`default_nettype wire

//--- test/timer_clock_source_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcsc_consts.svh"
module timer_clock_source_control_tb;
    import tcsc_pkg::*;
    localparam int W = 128;                  // running window in cycles
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;                // power reset, active low
    logic        hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        gate_set = 1'b0;            // random gate requests
    logic [31:0] hrdata, q, c0;
    logic        hreadyout, hresp, ext_clock_pin, crystal_in_pin, crystal_out_pin;
    logic        cap_sense_oscillator, dedicated_osc_enable, gate_ff, win = 1'b0;
    logic [15:0] timer_count;
    logic [7:0]  cfg;                        // control value under test
    integer n_errors = 0, comparisons = 0, cycles = 0, seed = 32'h2196;
    integer n_sys = 0, n_ext = 0, n_xtal = 0, n_cap = 0, exp_t;
    tcsc_top DUT (.ref_clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .ext_clock_pin,
        .crystal_in_pin, .crystal_out_pin, .cap_sense_oscillator, .gate_set,
        .dedicated_osc_enable, .gate_ff, .timer_count);
    tcsc_src_model SRC (.ext_clock_pin, .crystal_in_pin, .cap_sense_oscillator);
    // clock, 5 ns period
    initial forever #2.5 ref_clk = ~ref_clk;
    // reference tick counts inside the running window
    always @(posedge ref_clk) if (win) n_sys <= n_sys + 1;
    always @(posedge ext_clock_pin) if (win) n_ext = n_ext + 1;
    always @(posedge crystal_in_pin) if (win) n_xtal = n_xtal + 1;
    always @(posedge cap_sense_oscillator) if (win) n_cap = n_cap + 1;
    // random gate requests and hang guard
    always @(posedge ref_clk)
    begin
        gate_set <= 1'($random(seed));
        cycles <= cycles + 1;
        if (cycles == 9000)
        begin
            n_errors = n_errors + 1;
            summarize();
        end
    end
    // one single ahb-lite transfer; read data taken at the data phase edge
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    // exact compare
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // count compare, two ticks of slack for pin latency
    task cmp_near(input logic [31:0] got, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (^got === 1'bx || got + 2 < exp || got > exp + 2)
        begin
            n_errors = n_errors + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // counts, verdict, end of run
    task summarize();
        $display("errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        xfer(1'b0, `TCSC_ADDR_CONTROL, 32'h0000_0000, q);
        cmp(q, {24'h00_0000, `TCSC_CTRL_RESET});
        xfer(1'b0, `TCSC_ADDR_COUNT, 32'h0000_0000, q);
        cmp(q, {16'h0000, `TCSC_COUNT_RESET});
        xfer(1'b1, `TCSC_ADDR_CONTROL, 32'hffff_fffe, q);
        xfer(1'b0, `TCSC_ADDR_CONTROL, 32'h0000_0000, q);
        cmp(q, {24'h00_0000, 8'hfe & `TCSC_CTRL_WMASK});
        xfer(1'b0, 12'h00c, 32'h0000_0000, q);
        cmp(q, 32'h0000_0000);
        c0 = 32'h0000_0000;
        // every source, prescale and oscillator setting, random sync bit
        for (int k = 0; k < 32; k++)
        begin
            cfg = {k[3:0], k[4], 1'($random(seed)), 2'h0};
            n_sys = 0;
            n_ext = 0;
            n_xtal = 0;
            n_cap = 0;
            xfer(1'b1, `TCSC_ADDR_CONTROL, {24'h00_0000, cfg | 8'h01}, q);
            win <= 1'b1;
            repeat (W) @(posedge ref_clk);
            xfer(1'b1, `TCSC_ADDR_CONTROL, {24'h00_0000, cfg}, q);
            win <= 1'b0;
            xfer(1'b0, `TCSC_ADDR_COUNT, 32'h0000_0000, q);
            cmp(dedicated_osc_enable, cfg[3]);
            exp_t = cfg[7:6] == 2'h0 ? n_sys / `TCSC_INSTR_DIV : cfg[7:6] == 2'h1 ? n_sys :
                cfg[7:6] == 2'h3 ? n_cap : cfg[3] ? n_xtal : n_ext;
            exp_t = exp_t >> cfg[5:4];
            case (cfg[7:6])
                2'h0: cmp_near(q - c0, exp_t);
                2'h1: cmp_near(q - c0, exp_t);
                2'h2: cmp_near(q - c0, exp_t);
                default: cmp_near(q - c0, exp_t);
            endcase
            c0 = q;
            xfer(1'b0, `TCSC_ADDR_STATUS, 32'h0000_0000, q);
            cmp(q & 32'h0000_0002, 32'h0000_0000);
        end
        // power reset in mid-run while the timer runs
        xfer(1'b1, `TCSC_ADDR_CONTROL, 32'h0000_00fd, q);
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        xfer(1'b0, `TCSC_ADDR_CONTROL, 32'h0000_0000, q);
        cmp(q, {24'h00_0000, `TCSC_CTRL_RESET});
        xfer(1'b0, `TCSC_ADDR_COUNT, 32'h0000_0000, q);
        cmp(q, {16'h0000, `TCSC_COUNT_RESET});
        summarize();
    end
endmodule // timer_clock_source_control_tb
`default_nettype wire
